/* verilog/khc_pkg.sv */
// package: register map, field layouts, codes and timing for the keypad hmi control block
package khc_pkg;

  // register byte offsets (one aligned word each)
  localparam logic [7:0] OFS_USER_PASSWORD = 8'h00;
  localparam logic [7:0] OFS_COPY_MODE = 8'h04;
  localparam logic [7:0] OFS_QUICK_KEY = 8'h08;
  localparam logic [7:0] OFS_CHAN_SEQ = 8'h0C;
  localparam logic [7:0] OFS_STOP_VALID = 8'h10;
  localparam logic [7:0] OFS_RUN_MASK = 8'h14;
  localparam logic [7:0] OFS_PASSWORD_ENTRY = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1C;

  // reset values
  localparam logic [15:0] RST_USER_PASSWORD = 16'h0000;
  localparam logic [15:0] RST_COPY_MODE = 16'h0000;
  localparam logic [15:0] RST_QUICK_KEY = 16'h0001;
  localparam logic [15:0] RST_CHAN_SEQ = 16'h0000;
  localparam logic [15:0] RST_STOP_VALID = 16'h0000;
  localparam logic [15:0] RST_RUN_MASK = 16'h03FF;

  // quick key field limit
  localparam logic [15:0] QUICK_KEY_MAX = 16'h0027;

  // copy modes
  localparam logic [2:0] COPY_NONE = 3'h0;
  localparam logic [2:0] COPY_UPLOAD = 3'h1;
  localparam logic [2:0] COPY_DL_ALL = 3'h2;
  localparam logic [2:0] COPY_DL_NO_MOTOR = 3'h3;
  localparam logic [2:0] COPY_DL_MOTOR_ONLY = 3'h4;

  // quick key actions (low decimal digit)
  localparam logic [3:0] QK_NONE = 4'h0;
  localparam logic [3:0] QK_JOG = 4'h1;
  localparam logic [3:0] QK_DIR = 4'h3;
  localparam logic [3:0] QK_CLR_UPDN = 4'h4;
  localparam logic [3:0] QK_COAST = 4'h5;
  localparam logic [3:0] QK_CHAN = 4'h6;

  // status register bit positions
  localparam int ST_PROTECT = 0;
  localparam int ST_UNLOCKED = 1;
  localparam int ST_PROMPT = 2;
  localparam int ST_COPY_BUSY = 3;
  localparam int ST_CHAN_LSB = 4;
  localparam int ST_DISP_LSB = 8;

  // relock time after leaving the editing screen
  localparam int RELOCK_TIME_MS = 60000;
  localparam int CLK_MHZ = 125;
  localparam longint RELOCK_CYCLES_L = longint'(RELOCK_TIME_MS) * 1000 * CLK_MHZ;
  localparam logic [39:0] RELOCK_CYCLES = RELOCK_CYCLES_L[39:0];

  // run command source
  typedef enum logic [1:0] {
    KHC_SRC_KEYPAD = 2'h0,
    KHC_SRC_TERMINAL = 2'h1,
    KHC_SRC_COMM = 2'h2
  } khc_src_t;

  // key presses from keypad, one-cycle pulses after synchronising
  typedef struct packed {
    logic prog_esc;
    logic quick;
    logic stop_rst;
    logic shift;
  } khc_keys_t;

  // command pulses towards the drive
  typedef struct packed {
    logic jog;
    logic dir_toggle;
    logic clr_updn;
    logic coast;
    logic stop;
    logic fault_reset;
  } khc_cmd_t;

endpackage : khc_pkg

/* verilog/khc_top.sv */
// keypad hmi control: password lock, parameter copy, quick key, stop key, run display
//
// Overview of operation
// - password 0..65535; a non-zero write arms menu protection
// - writing zero clears the password and disables protection
// - while protected, menu entry needs the entered value to match the password
// - protection re-arms within one minute after leaving the editing screen
// - armed and program_escape_key pressed: show blank 0.0.0.0.0 prompt, need password
// - copy mode 0 none, 1 upload to keypad, 2 download including motor group
// - mode 3 downloads without motor group, mode 4 downloads motor group only
// - after any copy in modes 1..4 completes, the mode field returns to 0
// - copy skips excluded_parameter_group on keypad and drive alike
// - quick key field accepts 0x00..0x27 with action digit 0..7, resets to 0x01, tens digit reserved
// - action digit: 0 none, 1 jog, 3 direction, 4 clear up/down, 5 coast, 6 channel
// - action 6 steps run source per sequence 0 cycle, 1/2/3 toggle pairs
// - stop/reset key always resets an active fault
// - stop validity: 0 keypad, 1 keypad+terminal, 2 keypad+comm, 3 all sources
// - 16-bit running display mask, one shown value per bit, bit 0 first
// - running display mask resets to 0x03FF
`timescale 1ns/1ps

module khc_top (
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // keypad side, asynchronous key levels
  input wire logic key_prog_esc_pin,
  input wire logic key_quick_pin,
  input wire logic key_stop_rst_pin,
  input wire logic key_shift_pin,
  input wire logic running,
  input wire logic fault_active,
  input wire logic edit_exit,
  // parameter store copy handshake
  input wire logic copy_done,
  output logic copy_start,
  output logic [2:0] copy_mode,
  output logic copy_skip_excluded,
  output logic copy_motor_group,
  output logic copy_other_groups,
  // display and command outputs
  output logic prompt_blank,
  output logic menu_granted,
  output logic [3:0] display_sel,
  output logic [1:0] run_source,
  output khc_pkg::khc_cmd_t drive_cmd
);

  // registers
  logic [15:0] password_ff;
  logic [15:0] copy_mode_ff;
  logic [15:0] quick_key_ff;
  logic [15:0] chan_seq_ff;
  logic [15:0] stop_valid_ff;
  logic [15:0] run_mask_ff;
  logic protect_ff;
  logic unlocked_ff;
  logic prompt_ff;
  logic copy_busy_ff;
  logic copy_start_ff;
  logic motor_grp_ff;
  logic other_grp_ff;
  logic [39:0] relock_cnt_ff;
  logic relock_run_ff;
  logic [1:0] src_ff;
  logic [3:0] disp_ff;
  logic [31:0] hrdata_ff;
  khc_pkg::khc_cmd_t cmd_ff;

  // ahb address phase capture
  logic wr_pend_ff;
  logic [7:0] wr_addr_ff;

  // three-stage key synchronisers, edges counted once stages 2 and 3 agree
  logic [3:0] key_raw;
  logic [3:0] sync1_ff;
  logic [3:0] sync2_ff;
  logic [3:0] sync3_ff;
  logic [3:0] key_lvl_ff;
  logic [3:0] key_rise;
  khc_pkg::khc_keys_t keys;

  assign key_raw = {key_prog_esc_pin, key_quick_pin, key_stop_rst_pin, key_shift_pin};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_key
      // filtered level moves only on agreement of the late stages
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          sync1_ff[gi] <= 1'b0;
          sync2_ff[gi] <= 1'b0;
          sync3_ff[gi] <= 1'b0;
          key_lvl_ff[gi] <= 1'b0;
        end else begin
          sync1_ff[gi] <= key_raw[gi];
          sync2_ff[gi] <= sync1_ff[gi];
          sync3_ff[gi] <= sync2_ff[gi];
          if (sync2_ff[gi] == sync3_ff[gi]) begin
            key_lvl_ff[gi] <= sync3_ff[gi];
          end
        end
      end
      assign key_rise[gi] = (sync2_ff[gi] == sync3_ff[gi]) & sync3_ff[gi] & ~key_lvl_ff[gi];
    end
  endgenerate

  assign keys = key_rise;

  // bus decode
  wire addr_ok = hsel & hready & htrans[1];
  wire wr_req = addr_ok & hwrite;
  wire rd_req = addr_ok & ~hwrite;
  wire [15:0] wdat = hwdata[15:0];
  wire wr_pw = wr_pend_ff & (wr_addr_ff == khc_pkg::OFS_USER_PASSWORD);
  wire wr_cm = wr_pend_ff & (wr_addr_ff == khc_pkg::OFS_COPY_MODE);
  wire wr_qk = wr_pend_ff & (wr_addr_ff == khc_pkg::OFS_QUICK_KEY);
  wire wr_cs = wr_pend_ff & (wr_addr_ff == khc_pkg::OFS_CHAN_SEQ);
  wire wr_sv = wr_pend_ff & (wr_addr_ff == khc_pkg::OFS_STOP_VALID);
  wire wr_rm = wr_pend_ff & (wr_addr_ff == khc_pkg::OFS_RUN_MASK);
  wire wr_en = wr_pend_ff & (wr_addr_ff == khc_pkg::OFS_PASSWORD_ENTRY);

  // tens digit reserved: values above 0x27 or with bad action digit are ignored
  wire [3:0] qk_act = wdat[3:0];
  wire qk_ok = (wdat <= khc_pkg::QUICK_KEY_MAX) & (qk_act <= 4'h7) & (wdat[7:4] <= 4'h2);
  wire cm_ok = (wdat[2:0] <= khc_pkg::COPY_DL_MOTOR_ONLY) & (wdat[15:3] == 13'h0000);
  // copy mode only accepted while idle
  wire cm_go = wr_cm & cm_ok & ~copy_busy_ff & (wdat[2:0] != khc_pkg::COPY_NONE);

  // match the entry on its own write data phase; a stored copy would lag by a cycle
  wire pw_match = (wdat == password_ff);
  wire try_entry = wr_en & protect_ff & prompt_ff;

  // quick key action currently programmed
  wire [3:0] qk_sel = quick_key_ff[3:0];
  wire qk_hit = keys.quick;

  // next run source for channel stepping
  logic [1:0] nxt_src;
  always_comb begin
    nxt_src = src_ff;
    unique case (chan_seq_ff[1:0])
      2'h0: nxt_src = (src_ff == 2'h2) ? 2'h0 : src_ff + 2'h1;
      2'h1: nxt_src = (src_ff == 2'h0) ? 2'h1 : 2'h0;
      2'h2: nxt_src = (src_ff == 2'h0) ? 2'h2 : 2'h0;
      2'h3: nxt_src = (src_ff == 2'h1) ? 2'h2 : 2'h1;
    endcase
  end

  // stop key validity per source
  logic stop_ok;
  always_comb begin
    stop_ok = 1'b0;
    unique case (stop_valid_ff[1:0])
      2'h0: stop_ok = (src_ff == 2'h0);
      2'h1: stop_ok = (src_ff != 2'h2);
      2'h2: stop_ok = (src_ff != 2'h1);
      2'h3: stop_ok = 1'b1;
    endcase
  end

  // next enabled display slot, searched upward with wrap
  logic [3:0] nxt_disp;
  logic found;
  logic [3:0] idx;
  always_comb begin
    nxt_disp = disp_ff;
    found = 1'b0;
    idx = 4'h0;
    for (int k = 1; k <= 16; k++) begin
      idx = disp_ff + k[3:0];
      if (!found && run_mask_ff[idx]) begin
        nxt_disp = idx;
        found = 1'b1;
      end
    end
  end

  // read mux, narrow registers in low bits
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (haddr[7:0])
      khc_pkg::OFS_USER_PASSWORD: rd_mux = {16'h0000, password_ff};
      khc_pkg::OFS_COPY_MODE: rd_mux = {16'h0000, copy_mode_ff};
      khc_pkg::OFS_QUICK_KEY: rd_mux = {16'h0000, quick_key_ff};
      khc_pkg::OFS_CHAN_SEQ: rd_mux = {16'h0000, chan_seq_ff};
      khc_pkg::OFS_STOP_VALID: rd_mux = {16'h0000, stop_valid_ff};
      khc_pkg::OFS_RUN_MASK: rd_mux = {16'h0000, run_mask_ff};
      khc_pkg::OFS_STATUS: rd_mux = {20'h0_0000, disp_ff, 2'h0, src_ff, copy_busy_ff,
                                     prompt_ff, unlocked_ff, protect_ff};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // bus slave: zero wait states, always okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      hrdata_ff <= 32'h0000_0000;
    end else begin
      wr_pend_ff <= wr_req;
      wr_addr_ff <= haddr[7:0];
      if (rd_req) begin
        hrdata_ff <= rd_mux;
      end
    end
  end

  // configuration registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      password_ff <= khc_pkg::RST_USER_PASSWORD;
      quick_key_ff <= khc_pkg::RST_QUICK_KEY;
      chan_seq_ff <= khc_pkg::RST_CHAN_SEQ;
      stop_valid_ff <= khc_pkg::RST_STOP_VALID;
      run_mask_ff <= khc_pkg::RST_RUN_MASK;
    end else begin
      if (wr_pw) password_ff <= wdat;
      if (wr_qk && qk_ok) quick_key_ff <= wdat;
      if (wr_cs) chan_seq_ff <= {14'h0000, wdat[1:0]};
      if (wr_sv) stop_valid_ff <= {14'h0000, wdat[1:0]};
      if (wr_rm) run_mask_ff <= wdat;
    end
  end

  // password lock state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      protect_ff <= 1'b0;
      unlocked_ff <= 1'b1;
      prompt_ff <= 1'b0;
      relock_run_ff <= 1'b0;
      relock_cnt_ff <= 40'h00_0000_0000;
    end else begin
      if (wr_pw) begin
        protect_ff <= (wdat != 16'h0000);
        unlocked_ff <= (wdat == 16'h0000);
        prompt_ff <= 1'b0;
        relock_run_ff <= 1'b0;
      end else begin
        if (keys.prog_esc && protect_ff && !unlocked_ff) prompt_ff <= 1'b1;
        if (try_entry && pw_match) begin
          unlocked_ff <= 1'b1;
          prompt_ff <= 1'b0;
        end
        // leaving the editor starts the relock timer; counter sized for 60 s
        if (edit_exit && protect_ff && unlocked_ff) begin
          relock_run_ff <= 1'b1;
          relock_cnt_ff <= 40'h00_0000_0000;
        end else if (relock_run_ff) begin
          if (relock_cnt_ff >= khc_pkg::RELOCK_CYCLES - 40'h00_0000_0001) begin
            relock_run_ff <= 1'b0;
            unlocked_ff <= 1'b0;
          end else begin
            relock_cnt_ff <= relock_cnt_ff + 40'h00_0000_0001;
          end
        end
      end
    end
  end

  // copy sequencing: mode field self clears when the store reports done
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      copy_mode_ff <= khc_pkg::RST_COPY_MODE;
      copy_busy_ff <= 1'b0;
      copy_start_ff <= 1'b0;
      motor_grp_ff <= 1'b0;
      other_grp_ff <= 1'b0;
    end else begin
      copy_start_ff <= cm_go;
      if (cm_go) begin
        copy_mode_ff <= wdat;
        copy_busy_ff <= 1'b1;
        motor_grp_ff <= (wdat[2:0] != khc_pkg::COPY_DL_NO_MOTOR);
        other_grp_ff <= (wdat[2:0] != khc_pkg::COPY_DL_MOTOR_ONLY);
      end else if (copy_busy_ff && copy_done) begin
        copy_mode_ff <= khc_pkg::RST_COPY_MODE;
        copy_busy_ff <= 1'b0;
        motor_grp_ff <= 1'b0;
        other_grp_ff <= 1'b0;
      end
    end
  end

  // key commands, run source and display slot
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd_ff <= '0;
      src_ff <= 2'h0;
      disp_ff <= 4'h0;
    end else begin
      cmd_ff.jog <= qk_hit & (qk_sel == khc_pkg::QK_JOG);
      cmd_ff.dir_toggle <= qk_hit & (qk_sel == khc_pkg::QK_DIR);
      cmd_ff.clr_updn <= qk_hit & (qk_sel == khc_pkg::QK_CLR_UPDN);
      cmd_ff.coast <= qk_hit & (qk_sel == khc_pkg::QK_COAST);
      cmd_ff.stop <= keys.stop_rst & stop_ok;
      cmd_ff.fault_reset <= keys.stop_rst & fault_active;
      if (qk_hit && qk_sel == khc_pkg::QK_CHAN) src_ff <= nxt_src;
      if (!running) disp_ff <= 4'h0;
      else if (keys.shift) disp_ff <= nxt_disp;
    end
  end

  // copy group steering derived from active mode
  wire [2:0] cm_act = copy_mode_ff[2:0];

  assign hrdata = hrdata_ff;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign copy_start = copy_start_ff;
  assign copy_mode = cm_act;
  assign copy_skip_excluded = copy_busy_ff;
  assign copy_motor_group = motor_grp_ff;
  assign copy_other_groups = other_grp_ff;
  assign prompt_blank = prompt_ff;
  assign menu_granted = unlocked_ff;
  assign display_sel = disp_ff;
  assign run_source = src_ff;
  assign drive_cmd = cmd_ff;

endmodule : khc_top

/* verification/khc_top_properties.sv */
// checker: concurrent properties on the keypad hmi control ports
`timescale 1ns/1ps

module khc_top_properties (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic running,
  input wire logic copy_done,
  input wire logic copy_start,
  input wire logic [2:0] copy_mode,
  input wire logic copy_skip_excluded,
  input wire logic copy_motor_group,
  input wire logic copy_other_groups,
  input wire logic [3:0] display_sel,
  input wire logic [1:0] run_source,
  input khc_pkg::khc_cmd_t drive_cmd
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // copy busy in a given mode, and the store ending it
  sequence s_busy(logic [2:0] m);
    copy_skip_excluded && copy_mode == m;
  endsequence
  sequence s_copy_end;
    copy_skip_excluded && copy_done;
  endsequence

  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus slave stalled or answered an error");
  a_start_busy: assert property (copy_start |-> ##[0:1] copy_skip_excluded)
    else $error("copy started without skipping the excluded group");
  a_start_pulse: assert property (copy_start |=> !copy_start)
    else $error("copy start longer than one cycle");
  a_copy_clear: assert property (s_copy_end |=> !copy_skip_excluded)
    else $error("copy still busy after done");
  a_dl_all: assert property (s_busy(khc_pkg::COPY_DL_ALL) |->
    copy_motor_group && copy_other_groups)
    else $error("full download missing a group");
  a_dl_no_motor: assert property (s_busy(khc_pkg::COPY_DL_NO_MOTOR) |->
    !copy_motor_group && copy_other_groups)
    else $error("download without motor group touched wrong groups");
  a_dl_motor_only: assert property (s_busy(khc_pkg::COPY_DL_MOTOR_ONLY) |->
    copy_motor_group && !copy_other_groups)
    else $error("motor only download touched wrong groups");
  a_src_legal: assert property (run_source != 2'h3)
    else $error("run source out of range");
  a_disp_idle: assert property ((!running) [*2] |-> display_sel == 4'h0)
    else $error("display index not home while stopped");
  a_cmd_pulse: assert property (drive_cmd != '0 |=> drive_cmd == '0)
    else $error("drive command longer than one cycle");
endmodule : khc_top_properties

bind khc_top khc_top_properties u_props (.hclk(hclk), .hresetn(hresetn),
  .hreadyout(hreadyout), .hresp(hresp), .running(running), .copy_done(copy_done),
  .copy_start(copy_start), .copy_mode(copy_mode), .copy_skip_excluded(copy_skip_excluded),
  .copy_motor_group(copy_motor_group), .copy_other_groups(copy_other_groups),
  .display_sel(display_sel), .run_source(run_source), .drive_cmd(drive_cmd));

/* verification/khc_keypad_model.sv */
// partner: keypad keys and the parameter store copy handshake
`timescale 1ns/1ps

module khc_keypad_model (
  input wire logic hclk,
  input wire logic copy_start,
  output logic [3:0] keys,
  output logic copy_done
);
  initial keys = 4'h0;
  initial copy_done = 1'b0;

  // one press: held long enough to pass the filter, then a quiet gap
  task automatic press(input int k);
    @(posedge hclk) keys[k] <= 1'b1;
    repeat (6) @(posedge hclk);
    keys[k] <= 1'b0;
    repeat (10) @(posedge hclk);
  endtask : press

  // store answers after a random delay, quick or slow
  always @(posedge hclk) begin
    if (copy_start) begin
      repeat ($urandom_range(1, 30)) @(posedge hclk);
      copy_done <= 1'b1;
      @(posedge hclk) copy_done <= 1'b0;
    end
  end
endmodule : khc_keypad_model

/* verification/testbench.sv */
// testbench: register model, key scenarios and copy flow for khc_top
`timescale 1ns/1ps

module testbench;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, clr = 0;
  logic running = 0, fault_active = 0, edit_exit = 0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, q;
  logic [1:0] htrans = '0, run_source;
  logic [2:0] hsize = 3'h2, copy_mode, ms;
  logic hreadyout, hresp, copy_start, copy_done, csk, cmg, cog, prompt_blank, menu_granted;
  logic [3:0] display_sel, keys;
  logic [6:0] seen;
  logic [15:0] pw, mask;
  khc_pkg::khc_cmd_t drive_cmd;
  int fails = 0, checks = 0, src = 0, e, n;
  int mdl[9] = '{0, 0, 1, 0, 0, 'h3ff, 0, 0, 0};
  int qc[6] = '{1, 3, 4, 5, 0, 'h23};
  int qe[6] = '{'h20, 'h10, 'h08, 'h04, 0, 'h10};
  int sq[5] = '{0, 1, 2, 0, 3};
  int sc[5] = '{3, 2, 2, 1, 2};

  always #4 hclk = ~hclk;

  // collect pulses seen during one press or write
  always @(posedge hclk) begin
    seen <= clr ? 7'h00 : seen | {copy_start, drive_cmd};
    if (csk) ms <= copy_mode;
  end

  khc_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .key_prog_esc_pin(keys[3]),
    .key_quick_pin(keys[2]), .key_stop_rst_pin(keys[1]), .key_shift_pin(keys[0]),
    .running(running), .fault_active(fault_active), .edit_exit(edit_exit),
    .copy_done(copy_done), .copy_start(copy_start), .copy_mode(copy_mode),
    .copy_skip_excluded(csk), .copy_motor_group(cmg), .copy_other_groups(cog),
    .prompt_blank(prompt_blank), .menu_granted(menu_granted), .display_sel(display_sel),
    .run_source(run_source), .drive_cmd(drive_cmd));

  khc_keypad_model kp (.hclk(hclk), .copy_start(copy_start), .keys(keys),
    .copy_done(copy_done));

  task automatic tally_and_finish;
    if (fails == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_reg

  task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
    chk_reg({24'h0, got}, {24'h0, exp});
  endtask : chk_pin

  // bounded wait on hready, a stuck slave ends the run
  task automatic rdy;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      fails++;
      tally_and_finish;
    end
  endtask : rdy

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    rdy;
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    rdy;
    q = hrdata;
  endtask : bus

  // write and mirror into the model; copy field always reads back 0
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
    @(posedge hclk);
    if (a == 8'h00 || (a >= 8'h0c && a <= 8'h14)) mdl[a >> 2] = int'(d[15:0]);
    if (a == 8'h08 && d <= 32'h27 && d[3:0] <= 4'h7) mdl[2] = int'(d);
  endtask : wr

  task automatic rdc(input logic [7:0] a);
    bus(1'b0, a, 32'h0);
    chk_reg(q, 32'(mdl[a >> 2]));
  endtask : rdc

  task automatic key(input int k);
    clr <= 1'b1;
    @(posedge hclk) clr <= 1'b0;
    kp.press(k);
  endtask : key

  function automatic int nxt(input int s, input int c);
    case (s)
      0: return (c + 1) % 3;
      1: return c == 0 ? 1 : 0;
      2: return c == 0 ? 2 : 0;
      default: return c == 1 ? 2 : 1;
    endcase
  endfunction : nxt

  initial begin
    void'($urandom(92585));
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 9; i++) if (i != 7) rdc(8'(i * 4));
    pw = 16'($urandom) | 16'h0001;
    wr(8'h00, {16'h0, pw});
    wr(8'h14, $urandom);
    wr(8'h08, 32'h28);
    for (int i = 0; i < 6; i++) rdc(8'(i * 4));
    chk_pin(8'(menu_granted), 8'h0);
    key(3);
    chk_pin(8'(prompt_blank), 8'h1);
    wr(8'h18, {16'h0, pw ^ 16'h8000});
    chk_pin(8'(menu_granted), 8'h0);
    wr(8'h18, {16'h0, pw});
    chk_pin(8'(menu_granted), 8'h1);
    edit_exit <= 1'b1;
    @(posedge hclk) edit_exit <= 1'b0;
    wr(8'h00, 32'h0);
    rdc(8'h00);
    bus(1'b0, 8'h1c, 32'h0);
    chk_pin(8'(q[0]), 8'h0);
    // every copy mode 0..4, then one refused value 5
    for (int m = 0; m < 6; m++) begin
      clr <= 1'b1;
      @(posedge hclk) clr <= 1'b0;
      wr(8'h04, 32'(m));
      repeat (3) @(posedge hclk);
      for (n = 0; n < 100 && csk !== 1'b0; n++) @(posedge hclk);
      if (n >= 100) begin
        fails++;
        tally_and_finish;
      end
      rdc(8'h04);
      chk_pin(8'(seen[6]), 8'(m >= 1 && m <= 4));
      if (m >= 1 && m <= 4) chk_pin(8'(ms), 8'(m));
    end
    // quick key actions, one reserved tens digit among them
    for (int i = 0; i < 6; i++) begin
      wr(8'h08, 32'(qc[i]));
      rdc(8'h08);
      key(2);
      chk_pin(8'(seen), 8'(qe[i]));
    end
    wr(8'h08, 32'h6);
    for (int j = 0; j < 5; j++) begin
      wr(8'h0c, 32'(sq[j]));
      for (int p = 0; p < sc[j]; p++) begin
        key(2);
        src = nxt(sq[j], src);
        chk_pin(8'(run_source), 8'(src));
      end
    end
    // stop validity over every source and setting
    running <= 1'b1;
    wr(8'h0c, 32'h0);
    for (int s = 0; s < 3; s++) begin
      for (int v = 0; v < 4; v++) begin
        wr(8'h10, 32'(v));
        key(1);
        e = (src == 0 || v == 3 || (v == 1 && src == 1) || (v == 2 && src == 2)) ? 2 : 0;
        chk_pin(8'(seen), 8'(e));
      end
      key(2);
      src = nxt(0, src);
    end
    wr(8'h10, 32'h0);
    fault_active <= 1'b1;
    key(1);
    chk_pin(8'(seen[0]), 8'h1);
    fault_active <= 1'b0;
    // running display steps through set mask bits with wrap
    mask = 16'($urandom) | 16'h8001;
    wr(8'h14, {16'h0, mask});
    running <= 1'b0;
    repeat (3) @(posedge hclk);
    running <= 1'b1;
    e = 0;
    chk_pin(8'(display_sel), 8'h0);
    for (int p = 0; p <= $countones(mask); p++) begin
      key(0);
      do e = (e + 1) % 16; while (!mask[e]);
      chk_pin(8'(display_sel), 8'(e));
    end
    tally_and_finish;
  end
endmodule : testbench
